// File: verilog/qea_consts.svh
// constants of the quadrature encoder analyzer
`ifndef QEA_CONSTS_SVH
`define QEA_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define QEA_A_CTRL 8'h00
`define QEA_A_PPR 8'h04
`define QEA_A_FSS 8'h08
`define QEA_A_DLIM 8'h0C
`define QEA_A_PLIM 8'h10
`define QEA_A_LEVELS 8'h14
`define QEA_A_SPEED 8'h18
`define QEA_A_DUTY 8'h1C
`define QEA_A_POS 8'h20
`define QEA_A_PHASE 8'h24
`define QEA_A_REFPOS 8'h28
`define QEA_A_BARS 8'h2C
`define QEA_A_IST 8'h30
`define QEA_A_IMASK 8'h34
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define QEA_CTRL_CHB 0
`define QEA_CTRL_REF 1
`define QEA_EV_SPEED 0
`define QEA_EV_SEEN 1
`define QEA_EV_MISS 2
`define QEA_EV_STILL 3
`define QEA_RST_CTRL 2'h3
`define QEA_RST_PPR 16'h0400
`define QEA_RST_FSS 16'h0BB8
`define QEA_RST_DLIM 7'h14
`define QEA_RST_PLIM 8'h1E
// ----------------------------------------
// timing
// ----------------------------------------
`define QEA_CLK_HZ 56'h0000000BEBC200
`define QEA_RPM_NUM (56'h3C * `QEA_CLK_HZ)
`define QEA_STILL_MS 56'h64
`define QEA_STILL_CYC (`QEA_STILL_MS * `QEA_CLK_HZ / 56'h3E8)
`define QEA_BAR_FULL 5'h10
`define QEA_BAR_MID 16'sh0008
`endif

// File: verilog/qea_pkg.sv
// types of the quadrature encoder analyzer
package qea_pkg;
    typedef enum logic [1:0] {
        QEA_IDLE = 2'b01,
        QEA_RUN = 2'b10
    } qea_run_t;

    typedef struct packed {
        logic lvl;
        logic def;
    } qea_pin_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        qea_pin_t pin;
    } qea_sync_t;

    typedef struct packed {
        qea_run_t run;
        logic [31:0] idle;
        logic [31:0] per;
        logic [31:0] hia;
        logic [31:0] hib;
        logic [31:0] ph;
        logic [31:0] per_l;
        logic [2:0] prv;
        logic [15:0] pos;
        logic [15:0] rcnt;
        logic [8:0] rpos;
        logic rseen;
        logic rmiss;
        logic [16:0] speed;
        logic [6:0] da;
        logic [6:0] db;
        logic [8:0] phase;
        logic [1:0] ctrl;
        logic [15:0] ppr;
        logic [15:0] fss;
        logic [6:0] dlim;
        logic [7:0] plim;
        logic [3:0] ist;
        logic [3:0] imask;
        logic [31:0] rdata;
    } qea_st_t;
endpackage : qea_pkg

// File: verilog/qea_sync.sv
// three-stage synchroniser for one differential encoder input
`timescale 1ns/1ps
`default_nettype none
module qea_sync (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // differential pin pair
    input wire logic i_p,
    input wire logic i_n,
    // settled level
    output var qea_pkg::qea_pin_t o_pin
);
    qea_pkg::qea_sync_t q;
    qea_pkg::qea_sync_t d;

    always_comb begin
        d = q;
        d.s1 = {i_p, i_n};
        d.s2 = q.s1;
        d.s3 = q.s2;
        // equal legs mean an open or indeterminate input
        if (q.s2 == q.s3) begin
            d.pin.lvl = q.s3[1] & ~q.s3[0];
            d.pin.def = q.s3[1] ^ q.s3[0];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_pin = q.pin;
endmodule : qea_sync
`default_nettype wire

// File: verilog/qea_top.sv
// quadrature encoder analyzer: measurement, bars and register port
`timescale 1ns/1ps
`default_nettype none
`include "qea_consts.svh"
module qea_top #(
    parameter logic [31:0] STILL_CYC = 32'(`QEA_STILL_CYC)
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // encoder pins
    input wire logic i_channel_a_input_p,
    input wire logic i_channel_a_input_n,
    input wire logic i_channel_b_input_p,
    input wire logic i_channel_b_input_n,
    input wire logic i_reference_pulse_input_p,
    input wire logic i_reference_pulse_input_n,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // flags and interrupt
    output logic o_reference_seen_flag,
    output logic o_reference_missing_flag,
    output logic o_irq
);
    qea_pkg::qea_st_t q;
    qea_pkg::qea_st_t d;
    qea_pkg::qea_pin_t pin [3];
    logic [2:0] pp;
    logic [2:0] pn;
    logic rise_a;
    logic rise_b;
    logic rise_r;
    logic [11:0] lv_w;
    logic [8:0] pos_deg;
    logic [4:0] bar_spd;
    logic [4:0] bar_pos;
    logic [4:0] bar_ref;
    logic [4:0] bar_da;
    logic [4:0] bar_db;
    logic [4:0] bar_ph;
    logic [15:0] spd_mag;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [55:0] qea_div(input logic [55:0] n,
                                            input logic [55:0] m);
        // a zero divisor (unset config) yields zero, not x
        if (m == 56'h0) begin
            return 56'h0;
        end
        return n / m;
    endfunction : qea_div

    function automatic logic [4:0] qea_cbar(input logic signed [11:0] dv,
                                            input logic [7:0] lim);
        logic signed [15:0] v;
        v = `QEA_BAR_MID;
        if (lim != 8'h00) begin
            v = `QEA_BAR_MID + (16'(dv) * `QEA_BAR_MID)
                / $signed({8'h00, lim});
        end
        if (v < 16'sh0000) begin
            return 5'h00;
        end else if (v > 16'sh0010) begin
            return `QEA_BAR_FULL;
        end
        return v[4:0];
    endfunction : qea_cbar

    function automatic logic [4:0] qea_lbar(input logic [55:0] v,
                                            input logic [55:0] full);
        logic [55:0] t;
        t = qea_div(v * 56'h10, full);
        if (t > 56'h10) begin
            return `QEA_BAR_FULL;
        end
        return t[4:0];
    endfunction : qea_lbar

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    assign pp = {i_reference_pulse_input_p, i_channel_b_input_p,
                 i_channel_a_input_p};
    assign pn = {i_reference_pulse_input_n, i_channel_b_input_n,
                 i_channel_a_input_n};

    for (genvar g = 0; g < 3; g++) begin : g_sync
        qea_sync u_sync (
            .i_ref_clk(i_ref_clk),
            .i_rst(i_rst),
            .i_p(pp[g]),
            .i_n(pn[g]),
            .o_pin(pin[g])
        );
    end

    assign rise_a = pin[0].lvl & ~q.prv[0];
    assign rise_b = pin[1].lvl & ~q.prv[1] & q.ctrl[`QEA_CTRL_CHB];
    assign rise_r = pin[2].lvl & ~q.prv[2] & q.ctrl[`QEA_CTRL_REF];

    // ----------------------------------------
    // level view and bars
    // ----------------------------------------
    for (genvar g = 0; g < 3; g++) begin : g_lv
        assign lv_w[g*3] = pin[g].lvl;
        assign lv_w[g*3+1] = ~pin[g].def;
        assign lv_w[g*3+2] = pin[g].def & (q.run == qea_pkg::QEA_RUN);
    end
    assign lv_w[9] = q.rseen;
    assign lv_w[10] = q.rmiss;
    assign lv_w[11] = (q.run == qea_pkg::QEA_RUN);

    assign pos_deg = 9'(qea_div(56'(q.pos) * 56'h168, 56'(q.ppr)));
    assign spd_mag = q.speed[16] ? 16'(-q.speed) : q.speed[15:0];
    assign bar_spd = qea_lbar(56'(spd_mag), 56'(q.fss));
    assign bar_pos = qea_lbar(56'(pos_deg), 56'h168);
    assign bar_ref = qea_lbar(56'(q.rpos), 56'h168);
    assign bar_da = qea_cbar(12'(q.da) - 12'h032, 8'(q.dlim));
    assign bar_db = qea_cbar(12'(q.db) - 12'h032, 8'(q.dlim));
    assign bar_ph = qea_cbar(12'(q.phase) - 12'h05A, q.plim);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [55:0] t;
        logic [3:0] ev;
        logic [3:0] clr;
        logic neg;
        t = 56'h0;
        ev = 4'h0;
        clr = 4'h0;
        neg = 1'b0;
        d = q;
        // undefined pins hold prv high: settling after reset is no edge
        d.prv = {pin[2].lvl, pin[1].lvl, pin[0].lvl}
              | ~{pin[2].def, pin[1].def, pin[0].def};
        d.rdata = 32'h0;
        // standstill detection on edge silence
        if (rise_a || rise_b) begin
            d.idle = 32'h0;
            d.run = qea_pkg::QEA_RUN;
        end else if (q.idle >= STILL_CYC) begin
            d.run = qea_pkg::QEA_IDLE;
            ev[`QEA_EV_STILL] = (q.run == qea_pkg::QEA_RUN);
        end else begin
            d.idle = q.idle + 32'h1;
        end

        // period counters saturate instead of wrapping
        if (q.per != 32'hFFFFFFFF) begin
            d.per = q.per + 32'h1;
            d.ph = q.ph + 32'h1;
            d.hia = q.hia + 32'(pin[0].lvl);
            d.hib = q.hib + 32'(pin[1].lvl);
        end

        if (rise_a) begin
            d.per_l = q.per;
            d.per = 32'h1;
            d.ph = 32'h1;
            d.hia = 32'h1;
            d.hib = 32'(pin[1].lvl);
            t = qea_div(`QEA_RPM_NUM, 56'(q.per) * 56'(q.ppr));
            if (t > 56'hFFFF) begin
                t = 56'hFFFF;
            end
            neg = q.ctrl[`QEA_CTRL_CHB] & pin[1].lvl;
            d.speed = neg ? -{1'b0, t[15:0]} : {1'b0, t[15:0]};
            ev[`QEA_EV_SPEED] = 1'b1;
            d.da = 7'(qea_div(56'(q.hia) * 56'h64, 56'(q.per)));
            d.db = q.ctrl[`QEA_CTRL_CHB]
                 ? 7'(qea_div(56'(q.hib) * 56'h64, 56'(q.per))) : 7'h0;
            if (neg) begin
                d.pos = (q.pos == 16'h0 || q.pos >= q.ppr)
                      ? q.ppr - 16'h1 : q.pos - 16'h1;
            end else begin
                d.pos = (q.pos + 16'h1 >= q.ppr) ? 16'h0 : q.pos + 16'h1;
            end
            if (q.rcnt != 16'hFFFF) begin
                d.rcnt = q.rcnt + 16'h1;
            end
            if (q.rseen && q.rcnt >= q.ppr && !rise_r) begin
                d.rmiss = 1'b1;
                ev[`QEA_EV_MISS] = ~q.rmiss;
            end
        end

        // phase from rising A to rising B
        if (rise_b) begin
            t = qea_div(56'(q.ph) * 56'h168, 56'(q.per_l));
            d.phase = (t >= 56'h168) ? 9'h167 : t[8:0];
        end

        if (rise_r) begin
            d.rcnt = 16'h0;
            if (!q.rseen) begin
                d.rseen = 1'b1;
                ev[`QEA_EV_SEEN] = 1'b1;
            end
            d.rpos = pos_deg;
        end

        // register writes
        if (i_wr) begin
            case (i_addr)
                `QEA_A_CTRL: d.ctrl = i_wdata[1:0];
                `QEA_A_PPR: d.ppr = i_wdata[15:0];
                `QEA_A_FSS: d.fss = i_wdata[15:0];
                `QEA_A_DLIM: d.dlim = i_wdata[6:0];
                `QEA_A_PLIM: d.plim = i_wdata[7:0];
                `QEA_A_IMASK: d.imask = i_wdata[3:0];
                default: d.rdata = 32'h0;
            endcase
        end

        // register reads, unmapped offsets read zero
        if (i_rd) begin
            case (i_addr)
                `QEA_A_CTRL: d.rdata = 32'(q.ctrl);
                `QEA_A_PPR: d.rdata = 32'(q.ppr);
                `QEA_A_FSS: d.rdata = 32'(q.fss);
                `QEA_A_DLIM: d.rdata = 32'(q.dlim);
                `QEA_A_PLIM: d.rdata = 32'(q.plim);
                `QEA_A_LEVELS: d.rdata = 32'(lv_w);
                `QEA_A_SPEED: d.rdata = {{15{q.speed[16]}}, q.speed};
                `QEA_A_DUTY: d.rdata = {1'b0, 7'h64 - q.db, 1'b0, q.db,
                                        1'b0, 7'h64 - q.da, 1'b0, q.da};
                `QEA_A_POS: d.rdata = 32'(pos_deg);
                `QEA_A_PHASE: d.rdata = 32'(q.phase);
                `QEA_A_REFPOS: d.rdata = 32'(q.rpos);
                `QEA_A_BARS: d.rdata = {2'h0, bar_ph, bar_db, bar_da,
                                        bar_ref, bar_pos, bar_spd};
                `QEA_A_IST: begin
                    d.rdata = 32'(q.ist);
                    clr = 4'hF;
                end
                `QEA_A_IMASK: d.rdata = 32'(q.imask);
                default: d.rdata = 32'h0;
            endcase
        end
        // a new event in the clearing cycle survives
        d.ist = (q.ist & ~clr) | ev;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
            q.run <= qea_pkg::QEA_IDLE;
            q.ctrl <= `QEA_RST_CTRL;
            q.ppr <= `QEA_RST_PPR;
            q.fss <= `QEA_RST_FSS;
            q.dlim <= `QEA_RST_DLIM;
            q.plim <= `QEA_RST_PLIM;
        end else begin
            q <= d;
        end
    end

    assign o_rdata = q.rdata;
    assign o_reference_seen_flag = q.rseen;
    assign o_reference_missing_flag = q.rmiss;
    assign o_irq = |(q.ist & q.imask);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    property p_still_lvl;
        q.run == qea_pkg::QEA_IDLE && !rise_a
            |-> lv_w[0] == pin[0].lvl && !lv_w[2];
    endproperty
    a_still_lvl: assert property (p_still_lvl)
        else $error("standstill level view wrong");

    property p_undef;
        !pin[1].def |-> lv_w[4] && !lv_w[5];
    endproperty
    a_undef: assert property (p_undef)
        else $error("undefined input not flagged");

    property p_ack;
        rise_a && pin[0].def |=> lv_w[2];
    endproperty
    a_ack: assert property (p_ack)
        else $error("rotating input not acknowledged");

    property p_sign;
        rise_a && q.ctrl[0] && pin[1].lvl && q.per != 32'h0
            |=> q.speed[16] || q.speed == 17'h0;
    endproperty
    a_sign: assert property (p_sign)
        else $error("reverse speed not negative");

    property p_unsigned;
        rise_a && !q.ctrl[0] |=> !q.speed[16];
    endproperty
    a_unsigned: assert property (p_unsigned)
        else $error("single channel speed signed");

    property p_duty;
        rise_a |=> q.da <= 7'h64 && q.db <= 7'h64;
    endproperty
    a_duty: assert property (p_duty)
        else $error("duty above hundred percent");

    property p_pos;
        rise_a && q.pos < q.ppr && !i_wr |=> pos_deg < 9'h168;
    endproperty
    a_pos: assert property (p_pos)
        else $error("position beyond a turn");

    property p_refpos;
        rise_r |=> q.rseen && q.rpos == $past(pos_deg);
    endproperty
    a_refpos: assert property (p_refpos)
        else $error("reference position not captured");

    property p_miss;
        q.rmiss |=> q.rmiss[*8];
    endproperty
    a_miss: assert property (p_miss)
        else $error("reference error not latched");

    property p_turn;
        rise_a && q.rseen && !rise_r && q.rcnt >= q.ppr |=> q.rmiss;
    endproperty
    a_turn: assert property (p_turn)
        else $error("missing reference not detected");

    property p_bars;
        bar_spd <= 5'h10 && bar_da <= 5'h10 && bar_ph <= 5'h10;
    endproperty
    a_bars: assert property (p_bars)
        else $error("bar beyond full scale");

    c_seen: cover property (rise_r ##1 q.rseen);
    c_miss: cover property (q.rseen ##[1:1000] q.rmiss);
    c_still: cover property (q.run == qea_pkg::QEA_RUN
                             ##1 q.run == qea_pkg::QEA_IDLE);
    c_irq: cover property (o_irq);
endmodule : qea_top
`default_nettype wire

// File: tb/qea_enc_model.sv
// behavioural incremental encoder that drives the differential pins
`timescale 1ns/1ps
`default_nettype none
module qea_enc_model (
    // clock
    input wire logic i_ref_clk,
    // motion control
    input wire logic i_run,
    input wire logic i_rev,
    input wire logic i_ref_on,
    input wire logic [15:0] i_quarter,
    input wire logic [3:0] i_ref_every,
    // encoder pins
    output logic o_chan_a_p,
    output logic o_chan_a_n,
    output logic o_chan_b_p,
    output logic o_chan_b_n,
    output logic o_ref_p,
    output logic o_ref_n
);
    logic [17:0] phase_q = 18'h0;
    logic [3:0] turn_q = 4'h0;
    logic [17:0] q1, q2, q3;
    logic a_hi, b_hi, z_hi;

    assign q1 = {2'h0, i_quarter};
    assign q2 = {1'h0, i_quarter, 1'h0};
    assign q3 = q1 + q2;
    // one period is four quarters; a stop freezes the levels
    always @(posedge i_ref_clk) begin
        if (i_run) begin
            if (phase_q == {i_quarter, 2'h0} - 18'h1) begin
                phase_q <= 18'h0;
                if (turn_q == i_ref_every - 4'h1) begin
                    turn_q <= 4'h0;
                end else begin
                    turn_q <= turn_q + 4'h1;
                end
            end else begin
                phase_q <= phase_q + 18'h1;
            end
        end
    end
    assign a_hi = phase_q >= q2;
    // forward: b lags a by a quarter, reverse: b leads
    assign b_hi = i_rev ? (phase_q >= q1 && phase_q < q3) :
                  (phase_q >= q3 || phase_q < q1);
    assign z_hi = (turn_q == 4'h0) && a_hi && (phase_q < q3);
    assign o_chan_a_p = a_hi;
    assign o_chan_a_n = ~a_hi;
    assign o_chan_b_p = b_hi;
    assign o_chan_b_n = ~b_hi;
    // a switched-off reference looks like an open pair: equal legs
    assign o_ref_p = i_ref_on ? z_hi : 1'b1;
    assign o_ref_n = i_ref_on ? ~z_hi : 1'b1;
endmodule : qea_enc_model
`default_nettype wire

// File: tb/qea_top_test.sv
// self-checking bench of the quadrature encoder analyzer
`timescale 1ns/1ps
`default_nettype none
module qea_top_test;
    localparam logic [31:0] STILL = 32'h000007D0;
    localparam logic [7:0] RA [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                                      8'h34, 8'h3C};
    localparam logic [31:0] RV [7] = '{32'h3, 32'h400, 32'hBB8, 32'h14,
                                       32'h1E, 32'h0, 32'h0};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic run = 1'b0;
    logic rev = 1'b0;
    logic ref_on = 1'b0;
    logic rd_pend = 1'b0;
    logic [31:0] rdata;
    logic seen, miss, irq;
    logic a_p, a_n, b_p, b_n, z_p, z_n;
    logic [7:0] addr_q [$];
    logic [31:0] exp_q [$];
    logic [31:0] msk_q [$];
    int err_total = 0;
    int n_compared = 0;

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    qea_enc_model u_qea_enc_model (
        .i_ref_clk(ref_clk), .i_run(run), .i_rev(rev), .i_ref_on(ref_on),
        .i_quarter(16'h00C8), .i_ref_every(4'h4),
        .o_chan_a_p(a_p), .o_chan_a_n(a_n), .o_chan_b_p(b_p),
        .o_chan_b_n(b_n), .o_ref_p(z_p), .o_ref_n(z_n)
    );

    qea_top #(.STILL_CYC(STILL)) u_qea_top (
        .i_ref_clk(ref_clk), .i_rst(rst),
        .i_channel_a_input_p(a_p), .i_channel_a_input_n(a_n),
        .i_channel_b_input_p(b_p), .i_channel_b_input_n(b_n),
        .i_reference_pulse_input_p(z_p), .i_reference_pulse_input_n(z_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_reference_seen_flag(seen),
        .o_reference_missing_flag(miss), .o_irq(irq)
    );

    // ----------------------------------------
    // compare tasks and monitor
    // ----------------------------------------
    task automatic chk_word(input logic [7:0] a, input logic [31:0] e,
                            input logic [31:0] m);
        n_compared++;
        if ((rdata & m) !== (e & m)) begin
            err_total++;
            $display("[ERR] reg %h expected %h seen %h", a, e & m, rdata & m);
        end
    endtask : chk_word

    task automatic chk_bit(input string nm, input logic e, input logic s);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", nm, e, s);
        end
    endtask : chk_bit

    // read data stand only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_pend === 1'b1) begin
            chk_word(addr_q.pop_front(), exp_q.pop_front(), msk_q.pop_front());
        end
        rd_pend <= rd;
    end

    // ----------------------------------------
    // bus and wait tasks
    // ----------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] m);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        addr_q.push_back(a);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge ref_clk);
        rd <= 1'b0;
    endtask : rd_reg

    task automatic spin(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : spin

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        spin(100000);
        err_total++;
        complete_run();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] r;
        r = $urandom(75);
        spin(3);
        rst <= 1'b0;
        for (int k = 0; k < 7; k++) begin
            rd_reg(RA[k], RV[k], 32'hFFFFFFFF);
        end
        wr_reg(8'h18, $urandom());
        rd_reg(8'h18, 32'h0, 32'hFFFFFFFF);
        r = $urandom();
        wr_reg(8'h0C, r);
        rd_reg(8'h0C, r & 32'h7F, 32'hFFFFFFFF);
        spin(10);
        // standstill: a low, b high, reference open
        rd_reg(8'h14, 32'h088, 32'hFFF);
        $display("test reset and levels done");
        wr_reg(8'h04, 32'h00FA);
        wr_reg(8'h08, 32'hEA60);
        run <= 1'b1;
        // stop just after the 25th rise of a, 800-cycle period
        spin(19700);
        run <= 1'b0;
        spin(10);
        rd_reg(8'h20, 32'h24, 32'hFFFFFFFF);
        rd_reg(8'h18, 32'hEA60, 32'hFFFFFFFF);
        rd_reg(8'h1C, 32'h32323232, 32'hFFFFFFFF);
        rd_reg(8'h24, 32'h5A, 32'hFFFFFFFF);
        rd_reg(8'h2C, 32'h10840030, 32'hFFFFFFFF);
        rd_reg(8'h14, 32'h824, 32'h824);
        $display("test forward rotation done");
        rev <= 1'b1;
        run <= 1'b1;
        spin(8000);
        run <= 1'b0;
        spin(10);
        rd_reg(8'h18, 32'hFFFF15A0, 32'hFFFFFFFF);
        rd_reg(8'h24, 32'h10E, 32'hFFFFFFFF);
        $display("test reverse rotation done");
        wr_reg(8'h00, 32'h2);
        run <= 1'b1;
        spin(8000);
        rd_reg(8'h18, 32'hEA60, 32'hFFFFFFFF);
        rd_reg(8'h1C, 32'h64003232, 32'hFFFFFFFF);
        $display("test single channel done");
        wr_reg(8'h00, 32'h3);
        wr_reg(8'h04, 32'h4);
        wr_reg(8'h34, 32'h4);
        rev <= 1'b0;
        ref_on <= 1'b1;
        for (int k = 0; k < 4000 && seen !== 1'b1; k++) spin(1);
        if (seen !== 1'b1) begin
            err_total++;
            complete_run();
        end
        chk_bit("seen flag", 1'b1, seen);
        spin(3200);
        chk_bit("missing flag", 1'b0, miss);
        chk_bit("masked irq", 1'b0, irq);
        rd_reg(8'h18, 32'hFFFF, 32'hFFFFFFFF);
        ref_on <= 1'b0;
        for (int k = 0; k < 8000 && miss !== 1'b1; k++) spin(1);
        if (miss !== 1'b1) begin
            err_total++;
            complete_run();
        end
        chk_bit("irq", 1'b1, irq);
        rd_reg(8'h14, 32'h600, 32'h600);
        run <= 1'b0;
        spin(STILL + 200);
        rd_reg(8'h30, 32'hF, 32'hF);
        rd_reg(8'h30, 32'h0, 32'hF);
        spin(2);
        chk_bit("cleared irq", 1'b0, irq);
        chk_bit("latched missing", 1'b1, miss);
        $display("test reference done");
        complete_run();
    end
endmodule : qea_top_test
`default_nettype wire
